// File: verilog/gpm_params.svh
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// Register byte offsets
`define GPM_OFS_PIN_CTL 8'h14
`define GPM_OFS_PORT_CFG 8'h18
`define GPM_OFS_STATUS 8'h1C

// Pin control fields
`define GPM_EN_BIT 0
`define GPM_VAL_BIT 1
`define GPM_SRC_LSB 2
`define GPM_SRC_MSB 4
`define GPM_SEL_LSB 5
`define GPM_SEL_MSB 7

// Port configuration fields
`define GPM_PEN_LSB 0
`define GPM_PEN_MSB 3
`define GPM_PSEL_LSB 4
`define GPM_PSEL_MSB 7

// Status fields
`define GPM_ST_OE_BIT 0
`define GPM_ST_OUT_BIT 1

// Reset values and sizes
`define GPM_RST_PIN_CTL 8'h00
`define GPM_RST_PORT_CFG 8'h00
`define GPM_NPORT 4
`define GPM_DEC_W 8

`endif

// File: verilog/gpm_pkg.sv
package gpm_pkg;

    typedef enum logic [2:0] {
        GPM_SRC_RX0 = 3'b000,
        GPM_SRC_RX1 = 3'b001,
        GPM_SRC_RX2 = 3'b010,
        GPM_SRC_RX3 = 3'b011,
        GPM_SRC_DEV = 3'b100,
        GPM_SRC_RSV5 = 3'b101,
        GPM_SRC_TX = 3'b110,
        GPM_SRC_RSV7 = 3'b111
    } gpm_src_e;

    typedef struct packed {
        logic hready;
        logic [31:0] hrdata;
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [2:0] sel;
        gpm_src_e src;
        logic val;
        logic en;
        logic [3:0] port_en;
        logic [3:0] port_sel;
        logic pin_out;
        logic pin_oe;
    } gpm_state_s;

endpackage

// File: verilog/gpm_pin_mux.sv
`timescale 1ns/1ps
`include "gpm_params.svh"

module gpm_pin_mux
    import gpm_pkg::*;
#(
    parameter int NPORT = `GPM_NPORT
) (
    input wire logic [2:0] src, // Source code
    input wire logic [2:0] sel, // Signal select code
    input wire logic val, // Local value
    input wire logic [NPORT-1:0] port_en, // Enabled receive ports
    input wire logic [NPORT-1:0] port_sel, // Selected receive ports
    input wire logic [4*NPORT-1:0] rx_remote_gpio, // Four remote levels per port
    input wire logic [NPORT-1:0] rx_lock, // Lock per port
    input wire logic [NPORT-1:0] rx_pass, // Pass per port
    input wire logic [NPORT-1:0] rx_frame_valid, // Frame valid per port
    input wire logic [NPORT-1:0] rx_line_valid, // Line valid per port
    input wire logic frame_sync_pulse, // Internal frame sync
    input wire logic tx_frame_valid, // Output frame valid
    input wire logic tx_line_valid, // Output line valid
    input wire logic tx_synced, // Multi-port data synchronized
    input wire logic tx_irq, // Transmit port interrupt
    output logic level // Selected level
);

    logic [NPORT-1:0] port_lvl;
    logic dev_lvl;
    logic tx_lvl;

    // One signal per receive port
    genvar i;
    generate
        for (i = 0; i < NPORT; i++) begin : g_port
            always_comb begin
                case (sel)
                    3'h0: port_lvl[i] = rx_remote_gpio[4*i];
                    3'h1: port_lvl[i] = rx_remote_gpio[4*i+1];
                    3'h2: port_lvl[i] = rx_remote_gpio[4*i+3];
                    3'h4: port_lvl[i] = rx_lock[i];
                    3'h5: port_lvl[i] = rx_pass[i];
                    3'h6: port_lvl[i] = rx_frame_valid[i];
                    3'h7: port_lvl[i] = rx_line_valid[i];
                    default: port_lvl[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_comb begin
        case (sel)
            3'h0: dev_lvl = val;
            3'h1: dev_lvl = |(rx_lock & port_en);
            3'h2: dev_lvl = (|port_en) & (&(rx_pass | ~port_en));
            3'h4: dev_lvl = frame_sync_pulse;
            default: dev_lvl = 1'b0;
        endcase
    end

    always_comb begin
        case (sel)
            3'h0: tx_lvl = (|port_sel) & (&(rx_pass | ~port_sel));
            3'h1: tx_lvl = |(rx_pass & port_sel);
            3'h2: tx_lvl = tx_frame_valid;
            3'h3: tx_lvl = tx_line_valid;
            3'h4: tx_lvl = tx_synced;
            3'h5: tx_lvl = tx_irq;
            default: tx_lvl = 1'b0;
        endcase
    end

    // Same select code means different things per source
    always_comb begin
        case (src)
            GPM_SRC_RX0, GPM_SRC_RX1, GPM_SRC_RX2, GPM_SRC_RX3: begin
                level = port_lvl[src[1:0]];
            end
            GPM_SRC_DEV: level = dev_lvl;
            GPM_SRC_TX: level = tx_lvl;
            default: level = 1'b0;
        endcase
    end

endmodule

// File: verilog/gpm_pin4_ctrl.sv
`timescale 1ns/1ps
`include "gpm_params.svh"

module gpm_pin4_ctrl
    import gpm_pkg::*;
#(
    parameter int NPORT = `GPM_NPORT
) (
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic hreadyout, // Slave ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic [4*NPORT-1:0] rx_remote_gpio, // Remote GPIO0-3 per port
    input wire logic [NPORT-1:0] rx_lock, // Lock per port
    input wire logic [NPORT-1:0] rx_pass, // Pass per port
    input wire logic [NPORT-1:0] rx_frame_valid, // Frame valid per port
    input wire logic [NPORT-1:0] rx_line_valid, // Line valid per port
    input wire logic frame_sync_pulse, // Internal frame sync
    input wire logic tx_frame_valid, // Output frame valid
    input wire logic tx_line_valid, // Output line valid
    input wire logic tx_synced, // Multi-port data synchronized
    input wire logic tx_irq, // Transmit port interrupt
    output logic pin4_out, // Pin output level
    output logic pin4_oe // Pin output enable
);

    gpm_state_s state_reg;
    gpm_state_s state_next;
    logic mux_level;
    logic accept;
    logic addr_ok;

    // Read word for a register offset
    function automatic logic [31:0] rd_word(input gpm_state_s s, input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            `GPM_OFS_PIN_CTL: begin
                w[`GPM_SEL_MSB:`GPM_SEL_LSB] = s.sel;
                w[`GPM_SRC_MSB:`GPM_SRC_LSB] = s.src;
                w[`GPM_VAL_BIT] = s.val;
                w[`GPM_EN_BIT] = s.en;
            end
            `GPM_OFS_PORT_CFG: begin
                w[`GPM_PEN_MSB:`GPM_PEN_LSB] = s.port_en;
                w[`GPM_PSEL_MSB:`GPM_PSEL_LSB] = s.port_sel;
            end
            `GPM_OFS_STATUS: begin
                w[`GPM_ST_OE_BIT] = s.pin_oe;
                w[`GPM_ST_OUT_BIT] = s.pin_out;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    gpm_pin_mux #(
        .NPORT(NPORT)
    ) u_mux (
        .src(state_reg.src),
        .sel(state_reg.sel),
        .val(state_reg.val),
        .port_en(state_reg.port_en[NPORT-1:0]),
        .port_sel(state_reg.port_sel[NPORT-1:0]),
        .rx_remote_gpio(rx_remote_gpio),
        .rx_lock(rx_lock),
        .rx_pass(rx_pass),
        .rx_frame_valid(rx_frame_valid),
        .rx_line_valid(rx_line_valid),
        .frame_sync_pulse(frame_sync_pulse),
        .tx_frame_valid(tx_frame_valid),
        .tx_line_valid(tx_line_valid),
        .tx_synced(tx_synced),
        .tx_irq(tx_irq),
        .level(mux_level)
    );

    assign accept = hsel & htrans[1] & hready;
    assign addr_ok = (haddr[31:`GPM_DEC_W] == '0) && (haddr[1:0] == 2'h0);

    always_comb begin
        state_next = state_reg;
        state_next.hready = 1'b1;
        // Data phase of a write lands here
        if (state_reg.dph_wr) begin
            case (state_reg.dph_addr)
                `GPM_OFS_PIN_CTL: begin
                    state_next.sel = hwdata[`GPM_SEL_MSB:`GPM_SEL_LSB];
                    state_next.src = gpm_src_e'(hwdata[`GPM_SRC_MSB:`GPM_SRC_LSB]);
                    state_next.val = hwdata[`GPM_VAL_BIT];
                    state_next.en = hwdata[`GPM_EN_BIT];
                end
                `GPM_OFS_PORT_CFG: begin
                    state_next.port_en = hwdata[`GPM_PEN_MSB:`GPM_PEN_LSB];
                    state_next.port_sel = hwdata[`GPM_PSEL_MSB:`GPM_PSEL_LSB];
                end
                default: begin
                end
            endcase
        end
        // Address phase
        state_next.dph_wr = accept & hwrite & addr_ok;
        if (accept) begin
            state_next.dph_addr = addr_ok ? haddr[7:0] : 8'h00;
        end
        // Pin follows the stored control
        state_next.pin_oe = state_reg.en;
        state_next.pin_out = state_reg.en & mux_level;
        // Read data from the updated copy so a write just ahead is seen
        if (accept & ~hwrite) begin
            state_next.hrdata = rd_word(state_next, addr_ok ? haddr[7:0] : 8'h00);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_reg <= '0;
            state_reg.hready <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hreadyout = state_reg.hready;
    assign hresp = 1'b0;
    assign hrdata = state_reg.hrdata;
    assign pin4_out = state_reg.pin_out;
    assign pin4_oe = state_reg.pin_oe;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    logic rx_src;
    logic [1:0] pidx;
    logic dev_src;
    logic tx_src;
    logic pin_wr;
    assign rx_src = ~state_reg.src[2];
    assign pidx = state_reg.src[1:0];
    assign dev_src = state_reg.src == GPM_SRC_DEV;
    assign tx_src = state_reg.src == GPM_SRC_TX;
    assign pin_wr = state_reg.dph_wr && (state_reg.dph_addr == `GPM_OFS_PIN_CTL);

    bus_always_ready_a: assert property (
        hreadyout && !hresp
    ) else $error("slave not ready or error response");

    oe_from_write_a: assert property (
        pin_wr |-> ##2 (pin4_oe == $past(hwdata[`GPM_EN_BIT], 2))
    ) else $error("output enable does not follow written enable bit");

    low_when_off_a: assert property (
        !pin4_oe |-> !pin4_out
    ) else $error("pin driven high while disabled");

    ctl_readback_a: assert property (
        pin_wr ##1 (accept && !hwrite && haddr == 32'(`GPM_OFS_PIN_CTL))
        |=> hrdata[7:0] == $past(hwdata[7:0], 2)
    ) else $error("control register readback mismatch");

    rx_gpio0_a: assert property (
        (state_reg.en && rx_src && state_reg.sel == 3'h0)
        |=> pin4_out == $past(rx_remote_gpio[{pidx, 2'h0}])
    ) else $error("remote GPIO0 not driven");

    rx_gpio3_a: assert property (
        (state_reg.en && rx_src && state_reg.sel == 3'h2)
        |=> pin4_out == $past(rx_remote_gpio[{pidx, 2'h3}])
    ) else $error("remote GPIO3 not driven");

    rx_lock_a: assert property (
        (state_reg.en && rx_src && state_reg.sel == 3'h4)
        |=> pin4_out == $past(rx_lock[pidx])
    ) else $error("port lock not driven");

    rx_line_a: assert property (
        (state_reg.en && rx_src && state_reg.sel == 3'h7)
        |=> pin4_out == $past(rx_line_valid[pidx])
    ) else $error("port line valid not driven");

    local_value_a: assert property (
        (state_reg.en && dev_src && state_reg.sel == 3'h0)
        |=> pin4_out == $past(state_reg.val)
    ) else $error("local value not driven");

    lock_or_a: assert property (
        (state_reg.en && dev_src && state_reg.sel == 3'h1)
        |=> pin4_out == $past(|(rx_lock & state_reg.port_en))
    ) else $error("lock OR not driven");

    pass_and_a: assert property (
        (state_reg.en && dev_src && state_reg.sel == 3'h2 && state_reg.port_en == 4'hF)
        |=> pin4_out == $past(&rx_pass)
    ) else $error("pass AND not driven");

    frame_sync_a: assert property (
        (state_reg.en && dev_src && state_reg.sel == 3'h4)
        |=> pin4_out == $past(frame_sync_pulse)
    ) else $error("frame sync not driven");

    dev_reserved_a: assert property (
        (dev_src && state_reg.sel[2] && state_reg.sel[1:0] != 2'h0)
        |=> !pin4_out
    ) else $error("reserved device select drives high");

    tx_pass_and_a: assert property (
        (state_reg.en && tx_src && state_reg.sel == 3'h0 && state_reg.port_sel == 4'h0)
        |=> !pin4_out
    ) else $error("AND of no selected ports must be low");

    tx_pass_or_a: assert property (
        (state_reg.en && tx_src && state_reg.sel == 3'h1)
        |=> pin4_out == $past(|(rx_pass & state_reg.port_sel))
    ) else $error("pass OR not driven");

    tx_irq_a: assert property (
        (state_reg.en && tx_src && state_reg.sel == 3'h5)
        |=> pin4_out == $past(tx_irq)
    ) else $error("transmit interrupt not driven");

    tx_synced_a: assert property (
        (state_reg.en && tx_src && state_reg.sel == 3'h4)
        |=> pin4_out == $past(tx_synced)
    ) else $error("synchronized flag not driven");

    reserved_src_a: assert property (
        (state_reg.src == GPM_SRC_RSV5 || state_reg.src == GPM_SRC_RSV7)
        |=> !pin4_out
    ) else $error("reserved source drives high");

    rx_undefined_a: assert property (
        (rx_src && state_reg.sel == 3'h3) [*2] |-> !pin4_out
    ) else $error("undefined receive select drives high");

    cov_rx_lock_c: cover property (
        state_reg.en && rx_src && state_reg.sel == 3'h4 ##1 pin4_out
    );

    cov_dev_sync_c: cover property (
        state_reg.en && dev_src && state_reg.sel == 3'h4 ##1 pin4_out
    );

    cov_tx_irq_c: cover property (
        state_reg.en && tx_src && state_reg.sel == 3'h5 ##1 pin4_out
    );

    cov_enable_c: cover property (
        pin_wr ##2 $rose(pin4_oe)
    );

endmodule

// File: sim/gpm_board.sv
`timescale 1ns/1ps

module gpm_board (
    input wire logic pin4_out, // Level from the device
    input wire logic pin4_oe, // Device driving the pin
    output logic pin_level // Level seen on the board
);
    // Board pull-down sets the level while the device leaves the pin floating
    assign pin_level = pin4_oe ? pin4_out : 1'b0;
endmodule

// File: sim/gpio_pin_output_mux_bench.sv
`timescale 1ns/1ps
`include "gpm_params.svh"

module gpio_pin_output_mux_bench;
    localparam logic [31:0] A_CTL = {24'h0, `GPM_OFS_PIN_CTL};
    localparam logic [31:0] A_CFG = {24'h0, `GPM_OFS_PORT_CFG};
    localparam logic [31:0] A_ST = {24'h0, `GPM_OFS_STATUS};
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic hreadyout, hresp, pin4_out, pin4_oe, pin_level;
    wire logic [31:0] hrdata;
    logic [15:0] rx_remote_gpio = 16'h0;
    logic [3:0] rx_lock = 4'h0, rx_pass = 4'h0, rx_frame_valid = 4'h0, rx_line_valid = 4'h0;
    logic frame_sync_pulse = 1'b0, tx_frame_valid = 1'b0, tx_line_valid = 1'b0;
    logic tx_synced = 1'b0, tx_irq = 1'b0;
    logic [7:0] port_cfg = 8'h0;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    logic [31:0] rd;
    logic [1:0] ex;
    logic [36:0] pats [4] = '{{5'h15, 32'hA5C3_3C96}, {5'h0A, 32'h5A3C_C369},
        {5'h1F, 32'hFFFF_F0FF}, {5'h00, 32'h0F00_FFF0}};
    logic [7:0] cfgs [4] = '{8'hFF, 8'h5A, 8'h00, 8'hF3};

    always #5 sys_clk = ~sys_clk;

    gpm_pin4_ctrl DUT (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_remote_gpio(rx_remote_gpio), .rx_lock(rx_lock), .rx_pass(rx_pass),
        .rx_frame_valid(rx_frame_valid), .rx_line_valid(rx_line_valid),
        .frame_sync_pulse(frame_sync_pulse), .tx_frame_valid(tx_frame_valid),
        .tx_line_valid(tx_line_valid), .tx_synced(tx_synced), .tx_irq(tx_irq),
        .pin4_out(pin4_out), .pin4_oe(pin4_oe));

    gpm_board board (.pin4_out(pin4_out), .pin4_oe(pin4_oe), .pin_level(pin_level));

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        cmp_count++;
        if (seen !== expd) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, expd);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Single word transfer; address phase held until ready, then data phase
    task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                            output logic [31:0] rdv);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    // Expected {enable, level} for a control byte under the present inputs
    function automatic logic [1:0] model(input logic [7:0] c);
        logic lv;
        int p;
        p = int'(c[3:2]);
        lv = 1'b0;
        if (c[4] == 1'b0) begin
            case (c[7:5])
                3'd0: lv = rx_remote_gpio[4*p];
                3'd1: lv = rx_remote_gpio[4*p+1];
                3'd2: lv = rx_remote_gpio[4*p+3];
                3'd4: lv = rx_lock[p];
                3'd5: lv = rx_pass[p];
                3'd6: lv = rx_frame_valid[p];
                3'd7: lv = rx_line_valid[p];
                default: lv = 1'b0;
            endcase
        end else if (c[4:2] == 3'b100) begin
            case (c[7:5])
                3'd0: lv = c[1];
                3'd1: lv = |(rx_lock & port_cfg[3:0]);
                3'd2: lv = (port_cfg[3:0] != 4'h0) && (&(rx_pass | ~port_cfg[3:0]));
                3'd4: lv = frame_sync_pulse;
                default: lv = 1'b0;
            endcase
        end else if (c[4:2] == 3'b110) begin
            case (c[7:5])
                3'd0: lv = (port_cfg[7:4] != 4'h0) && (&(rx_pass | ~port_cfg[7:4]));
                3'd1: lv = |(rx_pass & port_cfg[7:4]);
                3'd2: lv = tx_frame_valid;
                3'd3: lv = tx_line_valid;
                3'd4: lv = tx_synced;
                3'd5: lv = tx_irq;
                default: lv = 1'b0;
            endcase
        end
        return {c[0], c[0] & lv};
    endfunction

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 12000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        check({31'h0, pin4_oe}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        ahb_xfer(A_CTL, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        for (int k = 0; k < 4; k++) begin
            {rx_remote_gpio, rx_lock, rx_pass, rx_frame_valid, rx_line_valid,
             frame_sync_pulse, tx_frame_valid, tx_line_valid, tx_synced, tx_irq} <= pats[k];
            port_cfg = cfgs[k];
            ahb_xfer(A_CFG, 1'b1, {24'h0, cfgs[k]}, rd);
            for (int c = 0; c < 256; c++) begin
                ahb_xfer(A_CTL, 1'b1, 32'(c), rd);
                repeat (3) @(posedge sys_clk);
                #1;
                ex = model(8'(c));
                check({30'h0, pin4_oe, pin4_out}, {30'h0, ex});
                check({31'h0, pin_level}, {31'h0, ex[0]});
            end
            ahb_xfer(A_CTL, 1'b0, 32'h0, rd);
            check(rd, 32'h0000_00FF);
            ahb_xfer(A_CFG, 1'b0, 32'h0, rd);
            check(rd, {24'h0, cfgs[k]});
            ahb_xfer(A_ST, 1'b0, 32'h0, rd);
            check(rd, {30'h0, ex[0], ex[1]});
        end
        ahb_xfer(32'h0000_0020, 1'b1, 32'h0000_0000, rd);
        ahb_xfer(32'h0000_0020, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        ahb_xfer(32'h0000_0015, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        ahb_xfer(A_CTL, 1'b0, 32'h0, rd);
        check(rd, 32'h0000_00FF);
        ahb_xfer(A_CTL, 1'b1, 32'hFFFF_FF13, rd);
        ahb_xfer(A_CTL, 1'b0, 32'h0, rd);
        check(rd, 32'h0000_0013);
        repeat (3) @(posedge sys_clk);
        #1;
        check({30'h0, pin4_oe, pin4_out}, 32'h3);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        #1;
        check({30'h0, pin4_oe, pin4_out}, 32'h0);
        ahb_xfer(A_CTL, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        tally_and_finish();
    end
endmodule
